/* hw/codec_cfg_pkg.sv */
package codec_cfg_pkg;

    // ------------------------------------------------------------
    // command byte layout
    // ------------------------------------------------------------
    localparam int CMD_WRITE_BIT = 7;
    localparam logic [6:0] ADDR_PLL = 7'h20;
    localparam logic [6:0] ADDR_SPARE = 7'h21;
    localparam logic [6:0] ADDR_PCM = 7'h22;
    localparam logic [6:0] ADDR_CLKCH = 7'h23;
    localparam logic [6:0] ADDR_RESET = 7'h24;
    localparam logic [6:0] ADDR_LOOP = 7'h25;
    localparam logic [6:0] ADDR_CONF = 7'h26;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PLL_SLEEP_BIT = 7;
    localparam int PCM_LINEAR_BIT = 7;
    localparam int PCM_ALAW_BIT = 6;
    localparam int PCM_DBL_BIT = 5;
    localparam int PCM_EDGE_LSB = 3;
    localparam int PCM_OFS_LSB = 0;
    localparam int CH_GATE_LSB = 4;
    localparam int MCLK_SEL_LSB = 0;
    localparam int RST_FULL_BIT = 7;
    localparam int RST_CHAN_BIT = 5;
    localparam int RST_MASK_LSB = 0;
    localparam int LOOP_A_WIDE_BIT = 6;
    localparam int LOOP_A_NARROW_BIT = 5;
    localparam int LOOP_A_HWY_BIT = 4;
    localparam int LOOP_D_WIDE_BIT = 2;
    localparam int LOOP_D_NARROW_BIT = 1;
    localparam int LOOP_D_HWY_BIT = 0;
    localparam int CONF_INT_BIT = 3;
    localparam int CONF_EXT_BIT = 2;
    localparam int CONF_PICK_LSB = 0;

    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] PLL_RESET = 8'h00;
    localparam logic [7:0] PCM_RESET = 8'h40;
    localparam logic [7:0] CLKCH_RESET = 8'h02;
    localparam logic [7:0] LOOP_RESET = 8'h00;
    localparam logic [7:0] CONF_RESET = 8'h00;
    localparam logic [7:0] PLL_MASK = 8'h80;
    localparam logic [7:0] LOOP_MASK = 8'h77;
    localparam logic [7:0] CONF_MASK = 8'h0F;
    localparam logic [3:0] MCLK_2M048 = 4'h2;
    localparam logic [3:0] MCLK_4M096 = 4'h1;

    // ------------------------------------------------------------
    // data clock rate detection
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int DCL_SLOW_PERIOD_NS = 488;
    localparam int DCL_FAST_PERIOD_NS = 244;
    localparam int DCL_SPLIT_CYCLES =
        ((DCL_SLOW_PERIOD_NS + DCL_FAST_PERIOD_NS) / 2) * CLK_MHZ / 1000;

endpackage

/* hw/host_port_shifter.sv */
`timescale 1ns/1ps
module host_port_shifter (
    // clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // serial pins
    input wire logic sel_n_in,
    input wire logic sclk_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_n_out,
    // byte side
    input wire logic tx_load_in,
    input wire logic [7:0] tx_byte_in,
    output logic rx_valid_out,
    output logic [7:0] rx_byte_out,
    output logic frame_end_out
);
    logic [1:0] sel_sync_r, clk_sync_r, din_sync_r;
    logic clk_prev_r, sel_prev_r, tx_act_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] rx_sr_r, tx_sr_r;
    wire active = ~sel_sync_r[1];
    wire rise = active & clk_sync_r[1] & ~clk_prev_r;
    wire fall = active & ~clk_sync_r[1] & clk_prev_r;
    wire byte_done = rise & (bit_cnt_r == 3'd7);

    always_ff @(posedge mclk_in) begin
        sel_sync_r <= {sel_sync_r[0], sel_n_in};
        clk_sync_r <= {clk_sync_r[0], sclk_in};
        din_sync_r <= {din_sync_r[0], sdi_in};
        clk_prev_r <= clk_sync_r[1];
        sel_prev_r <= sel_sync_r[1];
    end

    // receive: msb first on rising edges of the serial clock
    always_ff @(posedge mclk_in) begin
        if (reset_in || !active) begin
            bit_cnt_r <= 3'd0;
            rx_valid_out <= 1'b0;
        end else begin
            rx_valid_out <= byte_done;
            if (rise) begin
                bit_cnt_r <= bit_cnt_r + 3'd1;
                rx_sr_r <= {rx_sr_r[6:0], din_sync_r[1]};
            end
        end
        if (byte_done) begin
            rx_byte_out <= {rx_sr_r[6:0], din_sync_r[1]};
        end
        if (reset_in) begin
            rx_byte_out <= 8'h00;
            rx_sr_r <= 8'h00;
        end
        frame_end_out <= ~reset_in & sel_sync_r[1] & ~sel_prev_r;
    end

    // transmit: shift only after a rising edge of the current byte, so the
    // falling edge that ends the command byte cannot eat the first bit
    always_ff @(posedge mclk_in) begin
        if (reset_in || !active) begin
            tx_act_r <= 1'b0;
            tx_sr_r <= 8'h00;
        end else if (tx_load_in) begin
            tx_act_r <= 1'b1;
            tx_sr_r <= tx_byte_in;
        end else begin
            if (fall && bit_cnt_r != 3'd0) begin
                tx_sr_r <= {tx_sr_r[6:0], 1'b0};
            end
            if (byte_done) begin
                tx_act_r <= 1'b0;
            end
        end
        sdo_out <= tx_sr_r[7] & tx_act_r;
        sdo_oe_n_out <= ~tx_act_r;
    end
endmodule // host_port_shifter

/* hw/dcl_rate_detect.sv */
`timescale 1ns/1ps
module dcl_rate_detect #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // data clock pin
    input wire logic dcl_in,
    // result
    output logic fast_out,
    output logic seen_out
);
    logic [1:0] dcl_sync_r;
    logic dcl_prev_r;
    logic [CNT_W-1:0] cnt_r;
    wire edge_seen = dcl_sync_r[1] & ~dcl_prev_r;
    wire cnt_full = &cnt_r;

    always_ff @(posedge mclk_in) begin
        dcl_sync_r <= {dcl_sync_r[0], dcl_in};
        dcl_prev_r <= dcl_sync_r[1];
        if (reset_in) begin
            cnt_r <= '0;
            fast_out <= 1'b0;
            seen_out <= 1'b0;
        end else if (edge_seen) begin
            // period below the midpoint of the two periods means the fast one
            fast_out <= (cnt_r < CNT_W'(codec_cfg_pkg::DCL_SPLIT_CYCLES));
            seen_out <= 1'b1;
            cnt_r <= '0;
        end else if (!cnt_full) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule // dcl_rate_detect

/* hw/codec_global_config_regs.sv */
`timescale 1ns/1ps
module codec_global_config_regs #(
    parameter logic [7:0] VERSION_CODE = 8'hC3, // arbitrary value
    parameter int DCL_CNT_W = 8
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // port mode strap: high selects gci
    input wire logic gci_mode_in,
    // host processor port pins
    input wire logic host_sel_n_in,
    input wire logic host_sclk_in,
    input wire logic host_sdi_in,
    output logic host_sdo_out,
    output logic host_sdo_oe_n_out,
    // gci data clock
    input wire logic dcl_in,
    // pll and clocking
    output logic phase_lock_sleep_out,
    output logic [3:0] mclk_sel_out,
    // pcm highway format
    output logic linear_word_out,
    output logic a_law_out,
    output logic twice_rate_bit_clock_out,
    output logic [1:0] edge_polarity_sel_out,
    output logic tx_on_rise_out,
    output logic rx_on_rise_out,
    output logic [2:0] frame_sync_offset_out,
    // channel gating and resets
    output logic [3:0] channel_program_gate_out,
    output logic full_reset_trigger_out,
    output logic [3:0] channel_reset_out,
    // test loopbacks
    output logic analog_loop_wide_out,
    output logic analog_loop_narrow_out,
    output logic analog_loop_highway_out,
    output logic digital_loop_wide_out,
    output logic digital_loop_narrow_out,
    output logic digital_loop_highway_out,
    // conference
    output logic internal_conference_on_out,
    output logic external_conference_on_out,
    output logic [1:0] conference_channel_pick_out
);

    // ------------------------------------------------------------
    // types and storage
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_CMD,
        ST_WDATA,
        ST_RDATA
    } host_state_t;

    host_state_t state_r, state_nxt;
    logic [6:0] addr_r, addr_nxt;
    logic [7:0] pll_r, pcm_r, clkch_r, loop_r, conf_r;
    logic [1:0] mode_sync_r;
    logic full_reset_r, chan_reset_r;
    logic [3:0] chan_mask_r;
    logic tx_load_r;
    logic [7:0] tx_byte_r;

    // ------------------------------------------------------------
    // byte transport and data clock detection
    // ------------------------------------------------------------
    wire rx_valid;
    wire [7:0] rx_byte;
    wire frame_end;
    wire dcl_fast;
    wire dcl_seen;
    // the full reset trigger clears the bank exactly as the pin does
    wire bank_reset = reset_in | full_reset_r;

    host_port_shifter host_port_shifter_i (
        .mclk_in(mclk_in),
        .reset_in(bank_reset),
        .sel_n_in(host_sel_n_in),
        .sclk_in(host_sclk_in),
        .sdi_in(host_sdi_in),
        .sdo_out(host_sdo_out),
        .sdo_oe_n_out(host_sdo_oe_n_out),
        .tx_load_in(tx_load_r),
        .tx_byte_in(tx_byte_r),
        .rx_valid_out(rx_valid),
        .rx_byte_out(rx_byte),
        .frame_end_out(frame_end)
    );

    dcl_rate_detect #(
        .CNT_W(DCL_CNT_W)
    ) dcl_rate_detect_i (
        .mclk_in(mclk_in),
        .reset_in(bank_reset),
        .dcl_in(dcl_in),
        .fast_out(dcl_fast),
        .seen_out(dcl_seen)
    );

    // strap comes from a pin, so it is synchronised before use
    always_ff @(posedge mclk_in) begin
        mode_sync_r <= {mode_sync_r[0], gci_mode_in};
    end
    wire gci_mode = mode_sync_r[1];

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire cmd_is_write = rx_byte[codec_cfg_pkg::CMD_WRITE_BIT];
    wire [6:0] cmd_addr = rx_byte[6:0];
    wire take_cmd = rx_valid & (state_r == ST_CMD);
    wire take_wdata = rx_valid & (state_r == ST_WDATA);
    wire wr_pll = take_wdata & (addr_r == codec_cfg_pkg::ADDR_PLL);
    wire wr_pcm = take_wdata & (addr_r == codec_cfg_pkg::ADDR_PCM);
    wire wr_clkch = take_wdata & (addr_r == codec_cfg_pkg::ADDR_CLKCH);
    wire wr_reset = take_wdata & (addr_r == codec_cfg_pkg::ADDR_RESET);
    wire wr_loop = take_wdata & (addr_r == codec_cfg_pkg::ADDR_LOOP);
    wire wr_conf = take_wdata & (addr_r == codec_cfg_pkg::ADDR_CONF);
    wire mapped_rd = take_cmd & ~cmd_is_write;

    // reserved bits are never stored, so they read back as zero
    wire [7:0] rd_data =
        (cmd_addr == codec_cfg_pkg::ADDR_PLL)   ? pll_r :
        (cmd_addr == codec_cfg_pkg::ADDR_PCM)   ? pcm_r :
        (cmd_addr == codec_cfg_pkg::ADDR_CLKCH) ? clkch_r :
        (cmd_addr == codec_cfg_pkg::ADDR_RESET) ? VERSION_CODE :
        (cmd_addr == codec_cfg_pkg::ADDR_LOOP)  ? loop_r :
        (cmd_addr == codec_cfg_pkg::ADDR_CONF)  ? conf_r :
        8'h00;

    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        case (state_r)
            ST_CMD: begin
                if (rx_valid) begin
                    addr_nxt = cmd_addr;
                    state_nxt = cmd_is_write ? ST_WDATA : ST_RDATA;
                end
            end
            ST_WDATA: begin
                if (rx_valid) begin
                    state_nxt = ST_CMD;
                end
            end
            ST_RDATA: begin
                // the byte clocked in during a read answer is discarded
                if (rx_valid) begin
                    state_nxt = ST_CMD;
                end
            end
            default: begin
                state_nxt = ST_CMD;
            end
        endcase
        if (frame_end) begin
            state_nxt = ST_CMD;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (bank_reset) begin
            state_r <= ST_CMD;
            addr_r <= 7'h00;
            tx_load_r <= 1'b0;
            tx_byte_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            tx_load_r <= mapped_rd;
            if (mapped_rd) begin
                tx_byte_r <= rd_data;
            end
        end
    end

    // ------------------------------------------------------------
    // global registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (bank_reset) begin
            pll_r <= codec_cfg_pkg::PLL_RESET;
            pcm_r <= codec_cfg_pkg::PCM_RESET;
            clkch_r <= codec_cfg_pkg::CLKCH_RESET;
            loop_r <= codec_cfg_pkg::LOOP_RESET;
            conf_r <= codec_cfg_pkg::CONF_RESET;
            chan_mask_r <= 4'h0;
        end else begin
            if (wr_pll) begin
                pll_r <= rx_byte & codec_cfg_pkg::PLL_MASK;
            end
            if (wr_pcm) begin
                pcm_r <= rx_byte;
            end
            if (wr_clkch) begin
                clkch_r <= rx_byte;
            end
            if (wr_loop) begin
                loop_r <= rx_byte & codec_cfg_pkg::LOOP_MASK;
            end
            if (wr_conf) begin
                conf_r <= rx_byte & codec_cfg_pkg::CONF_MASK;
            end
            if (wr_reset) begin
                chan_mask_r <= rx_byte[codec_cfg_pkg::RST_MASK_LSB +: 4];
            end
        end
    end

    // ------------------------------------------------------------
    // reset triggers
    // ------------------------------------------------------------
    // one-cycle pulses; nothing holds them, so a read never sees them
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            full_reset_r <= 1'b0;
        end else begin
            full_reset_r <= wr_reset & rx_byte[codec_cfg_pkg::RST_FULL_BIT];
        end
        if (bank_reset) begin
            chan_reset_r <= 1'b0;
        end else begin
            chan_reset_r <= wr_reset & rx_byte[codec_cfg_pkg::RST_CHAN_BIT];
        end
    end

    // ------------------------------------------------------------
    // derived controls
    // ------------------------------------------------------------
    wire [1:0] edge_code = pcm_r[codec_cfg_pkg::PCM_EDGE_LSB +: 2];
    // 00 tx rise/rx fall, 01 both rise, 10 both fall, 11 tx fall/rx rise
    wire tx_rise = ~edge_code[1];
    wire rx_rise = edge_code[0];
    wire host_mode = ~gci_mode;
    wire [3:0] gci_mclk = dcl_fast ? codec_cfg_pkg::MCLK_4M096 : codec_cfg_pkg::MCLK_2M048;
    // until a data clock edge is seen the slower rate is assumed
    wire [3:0] mclk_eff = gci_mode ? (dcl_seen ? gci_mclk : codec_cfg_pkg::MCLK_2M048)
                                   : clkch_r[codec_cfg_pkg::MCLK_SEL_LSB +: 4];
    wire [3:0] chan_gate = host_mode ? clkch_r[codec_cfg_pkg::CH_GATE_LSB +: 4] : 4'hF;
    wire [3:0] chan_rst = chan_reset_r ? chan_mask_r : 4'h0;

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            phase_lock_sleep_out <= 1'b0;
            mclk_sel_out <= codec_cfg_pkg::MCLK_2M048;
            linear_word_out <= 1'b0;
            a_law_out <= 1'b1;
            twice_rate_bit_clock_out <= 1'b0;
            edge_polarity_sel_out <= 2'b00;
            tx_on_rise_out <= 1'b1;
            rx_on_rise_out <= 1'b0;
            frame_sync_offset_out <= 3'd0;
            channel_program_gate_out <= 4'h0;
            full_reset_trigger_out <= 1'b0;
            channel_reset_out <= 4'h0;
        end else begin
            phase_lock_sleep_out <= pll_r[codec_cfg_pkg::PLL_SLEEP_BIT];
            mclk_sel_out <= mclk_eff;
            linear_word_out <= pcm_r[codec_cfg_pkg::PCM_LINEAR_BIT];
            a_law_out <= pcm_r[codec_cfg_pkg::PCM_ALAW_BIT];
            twice_rate_bit_clock_out <= host_mode & pcm_r[codec_cfg_pkg::PCM_DBL_BIT];
            edge_polarity_sel_out <= edge_code;
            tx_on_rise_out <= host_mode ? tx_rise : 1'b1;
            rx_on_rise_out <= host_mode ? rx_rise : 1'b0;
            frame_sync_offset_out <= host_mode ? pcm_r[codec_cfg_pkg::PCM_OFS_LSB +: 3] : 3'd0;
            channel_program_gate_out <= chan_gate;
            full_reset_trigger_out <= full_reset_r;
            channel_reset_out <= chan_rst;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            analog_loop_wide_out <= 1'b0;
            analog_loop_narrow_out <= 1'b0;
            analog_loop_highway_out <= 1'b0;
            digital_loop_wide_out <= 1'b0;
            digital_loop_narrow_out <= 1'b0;
            digital_loop_highway_out <= 1'b0;
            internal_conference_on_out <= 1'b0;
            external_conference_on_out <= 1'b0;
            conference_channel_pick_out <= 2'b00;
        end else begin
            analog_loop_wide_out <= loop_r[codec_cfg_pkg::LOOP_A_WIDE_BIT];
            analog_loop_narrow_out <= loop_r[codec_cfg_pkg::LOOP_A_NARROW_BIT];
            analog_loop_highway_out <= host_mode & loop_r[codec_cfg_pkg::LOOP_A_HWY_BIT];
            digital_loop_wide_out <= loop_r[codec_cfg_pkg::LOOP_D_WIDE_BIT];
            digital_loop_narrow_out <= loop_r[codec_cfg_pkg::LOOP_D_NARROW_BIT];
            digital_loop_highway_out <= host_mode & loop_r[codec_cfg_pkg::LOOP_D_HWY_BIT];
            internal_conference_on_out <= conf_r[codec_cfg_pkg::CONF_INT_BIT];
            external_conference_on_out <= conf_r[codec_cfg_pkg::CONF_EXT_BIT];
            conference_channel_pick_out <= conf_r[codec_cfg_pkg::CONF_PICK_LSB +: 2];
        end
    end

endmodule // codec_global_config_regs

/* bench/host_port_model.sv */
`timescale 1ns/1ps
module host_port_model (
    // clock
    input wire logic mclk_in,
    // serial pins toward the device
    output logic sel_n_out,
    output logic sclk_out,
    output logic sdi_out,
    input wire logic sdo_in,
    input wire logic sdo_oe_n_in
);
    initial begin
        sel_n_out = 1'b1;
        sclk_out = 1'b1;
        sdi_out = 1'b0;
    end
    // msb first; answer sampled a cycle before the rise, where it cannot be moving
    task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sdi_out <= tx[i];
            sclk_out <= 1'b0;
            repeat (8) @(posedge mclk_in);
            rx[i] = sdo_oe_n_in ? 1'bx : sdo_in;
            @(posedge mclk_in);
            sclk_out <= 1'b1;
            repeat (8) @(posedge mclk_in);
        end
    endtask
    // released data line shows the inverse of its last bit
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] rd);
        logic [7:0] unused;
        sel_n_out <= 1'b0;
        repeat (8) @(posedge mclk_in);
        shift_byte(cmd, unused);
        shift_byte(dat, rd);
        sel_n_out <= 1'b1;
        sdi_out <= ~sdi_out;
        repeat (12) @(posedge mclk_in);
    endtask
endmodule // host_port_model

/* bench/codec_global_config_regs_chk.sv */
`timescale 1ns/1ps
module codec_cfg_chk (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic gci_mode_in,
    input wire logic host_sel_n_in,
    input wire logic host_sdo_out,
    input wire logic host_sdo_oe_n_out,
    input wire logic phase_lock_sleep_out,
    input wire logic [3:0] mclk_sel_out,
    input wire logic a_law_out,
    input wire logic twice_rate_bit_clock_out,
    input wire logic [1:0] edge_polarity_sel_out,
    input wire logic tx_on_rise_out,
    input wire logic rx_on_rise_out,
    input wire logic [2:0] frame_sync_offset_out,
    input wire logic [3:0] channel_program_gate_out,
    input wire logic full_reset_trigger_out,
    input wire logic [3:0] channel_reset_out,
    input wire logic analog_loop_highway_out,
    input wire logic digital_loop_highway_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    // strap must outlast the synchronizer and the output register
    sequence s_gci_held; gci_mode_in [*6]; endsequence
    sequence s_host_held; !gci_mode_in [*6]; endsequence
    sequence s_deselected; host_sel_n_in [*5]; endsequence
    property p_defaults;
        disable iff (1'b0) reset_in |=> a_law_out && mclk_sel_out == 4'h2 && !phase_lock_sleep_out;
    endproperty
    a_defaults: assert property (p_defaults) else $error("reset defaults wrong");
    property p_full_pulse; full_reset_trigger_out |=> !full_reset_trigger_out; endproperty
    a_full_pulse: assert property (p_full_pulse) else $error("full reset not one cycle");
    property p_chan_pulse; |channel_reset_out |=> channel_reset_out == 4'h0; endproperty
    a_chan_pulse: assert property (p_chan_pulse) else $error("channel reset not one cycle");
    property p_gci_force;
        s_gci_held |-> channel_program_gate_out == 4'hF && frame_sync_offset_out == 3'h0
            && !twice_rate_bit_clock_out && !analog_loop_highway_out && !digital_loop_highway_out;
    endproperty
    a_gci_force: assert property (p_gci_force) else $error("host-only field active in gci");
    property p_gci_mclk; s_gci_held |-> mclk_sel_out inside {4'h1, 4'h2}; endproperty
    a_gci_mclk: assert property (p_gci_mclk) else $error("gci clock code wrong");
    property p_edges;
        s_host_held |-> tx_on_rise_out == !edge_polarity_sel_out[1] && rx_on_rise_out == edge_polarity_sel_out[0];
    endproperty
    a_edges: assert property (p_edges) else $error("edge decode wrong");
    property p_oe_idle; s_deselected |-> host_sdo_oe_n_out; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("sdo driven while deselected");
    property p_sdo_idle; host_sdo_oe_n_out |-> !host_sdo_out; endproperty
    a_sdo_idle: assert property (p_sdo_idle) else $error("sdo not low when released");
endmodule // codec_cfg_chk
bind codec_global_config_regs codec_cfg_chk codec_cfg_chk_i (.mclk_in(mclk_in), .reset_in(reset_in),
    .gci_mode_in(gci_mode_in), .host_sel_n_in(host_sel_n_in), .host_sdo_out(host_sdo_out),
    .host_sdo_oe_n_out(host_sdo_oe_n_out), .phase_lock_sleep_out(phase_lock_sleep_out),
    .mclk_sel_out(mclk_sel_out), .a_law_out(a_law_out), .twice_rate_bit_clock_out(twice_rate_bit_clock_out),
    .edge_polarity_sel_out(edge_polarity_sel_out), .tx_on_rise_out(tx_on_rise_out),
    .rx_on_rise_out(rx_on_rise_out), .frame_sync_offset_out(frame_sync_offset_out),
    .channel_program_gate_out(channel_program_gate_out), .full_reset_trigger_out(full_reset_trigger_out),
    .channel_reset_out(channel_reset_out), .analog_loop_highway_out(analog_loop_highway_out),
    .digital_loop_highway_out(digital_loop_highway_out));

/* bench/codec_global_config_regs_tb.sv */
`timescale 1ns/1ps
module codec_global_config_regs_tb;
    localparam logic [7:0] VER = 8'h96; // arbitrary value
    logic mclk_in, reset_in, gci_mode_in, dcl_in, dcl_on, sel_n, sclk, sdi, sdo, sdo_oe_n, sleep, lin, alaw, dbl;
    logic txr, rxr, fr, aw, an, ah, dw, dn, dh, ci, ce;
    logic [1:0] edge_sel, pick;
    logic [2:0] ofs;
    logic [3:0] msel, gate, cr, cr_seen;
    logic [7:0] rd, d;
    int mismatches = 0, check_count = 0, fr_n = 0, cr_n = 0, dcl_half = 122;
    logic [7:0] dflt [7] = '{8'h00, 8'h00, 8'h40, 8'h02, VER, 8'h00, 8'h00};
    logic [3:0] mcodes [9] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'hE, 4'h5, 4'hD, 4'h4, 4'hC};
    logic [7:0] lbits [6] = '{8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h01};
    codec_global_config_regs #(.VERSION_CODE(VER), .DCL_CNT_W(8)) codec_global_config_regs_i (
        .mclk_in(mclk_in), .reset_in(reset_in), .gci_mode_in(gci_mode_in), .host_sel_n_in(sel_n),
        .host_sclk_in(sclk), .host_sdi_in(sdi), .host_sdo_out(sdo), .host_sdo_oe_n_out(sdo_oe_n), .dcl_in(dcl_in),
        .phase_lock_sleep_out(sleep), .mclk_sel_out(msel), .linear_word_out(lin), .a_law_out(alaw),
        .twice_rate_bit_clock_out(dbl), .edge_polarity_sel_out(edge_sel), .tx_on_rise_out(txr),
        .rx_on_rise_out(rxr), .frame_sync_offset_out(ofs), .channel_program_gate_out(gate),
        .full_reset_trigger_out(fr), .channel_reset_out(cr), .analog_loop_wide_out(aw),
        .analog_loop_narrow_out(an), .analog_loop_highway_out(ah), .digital_loop_wide_out(dw),
        .digital_loop_narrow_out(dn), .digital_loop_highway_out(dh), .internal_conference_on_out(ci),
        .external_conference_on_out(ce), .conference_channel_pick_out(pick));
    host_port_model host_port_model_i (.mclk_in(mclk_in), .sel_n_out(sel_n), .sclk_out(sclk), .sdi_out(sdi),
        .sdo_in(sdo), .sdo_oe_n_in(sdo_oe_n));
    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    // data clock toggles only while enabled; half period in ns
    initial begin
        dcl_in = 1'b0;
        forever begin
            #(dcl_half);
            if (dcl_on === 1'b1) dcl_in = ~dcl_in;
        end
    end
    always @(posedge mclk_in) begin
        if (fr === 1'b1) fr_n <= fr_n + 1;
        if (|cr === 1'b1) begin
            cr_n <= cr_n + 1;
            cr_seen <= cr;
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        host_port_model_i.xfer({1'b1, a}, v, rd);
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        host_port_model_i.xfer({1'b0, a}, 8'h00, rd);
        check(rd, exp);
    endtask
    task automatic give_verdict;
        if (mismatches == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge mclk_in);
        mismatches++;
        give_verdict();
    end
    initial begin
        reset_in = 1'b1;
        gci_mode_in = 1'b0;
        dcl_on = 1'b0;
        repeat (16) @(posedge mclk_in);
        reset_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        for (int a = 0; a < 7; a++) begin
            rd_chk(codec_cfg_pkg::ADDR_PLL + 7'(a), dflt[a]);
        end
        rd_chk(7'h30, 8'h00);
        wr(codec_cfg_pkg::ADDR_PLL, 8'h80);
        check({7'h00, sleep}, 8'h01);
        rd_chk(codec_cfg_pkg::ADDR_PLL, 8'h80);
        wr(codec_cfg_pkg::ADDR_PLL, 8'h00);
        check({7'h00, sleep}, 8'h00);
        for (int k = 0; k < 4; k++) begin
            d = {k[0], ~k[0], k[1], 2'(k), 2'(k), k[0]};
            wr(codec_cfg_pkg::ADDR_PCM, d);
            check({lin, alaw, dbl, edge_sel, ofs}, d);
            check({6'h00, txr, rxr}, {6'h00, ~d[4], d[3]});
            rd_chk(codec_cfg_pkg::ADDR_PCM, d);
        end
        for (int k = 0; k < 9; k++) begin
            d = {4'(k * 7 + 1), mcodes[k]};
            wr(codec_cfg_pkg::ADDR_CLKCH, d);
            check({gate, msel}, d);
            rd_chk(codec_cfg_pkg::ADDR_CLKCH, d);
        end
        for (int k = 0; k < 6; k++) begin
            wr(codec_cfg_pkg::ADDR_LOOP, lbits[k]);
            check({1'b0, aw, an, ah, 1'b0, dw, dn, dh}, lbits[k]);
            rd_chk(codec_cfg_pkg::ADDR_LOOP, lbits[k]);
        end
        for (int k = 0; k < 4; k++) begin
            d = {4'h0, k[1], k[0], 2'(k)};
            wr(codec_cfg_pkg::ADDR_CONF, d);
            check({4'h0, ci, ce, pick}, d);
            rd_chk(codec_cfg_pkg::ADDR_CONF, d);
        end
        wr(codec_cfg_pkg::ADDR_RESET, 8'h2A);
        check({4'h0, cr_seen}, 8'h0A);
        check(8'(cr_n + fr_n), 8'h01);
        rd_chk(codec_cfg_pkg::ADDR_PCM, 8'hBF);
        rd_chk(codec_cfg_pkg::ADDR_RESET, VER);
        wr(codec_cfg_pkg::ADDR_RESET, 8'h00);
        check(8'(cr_n + fr_n), 8'h01);
        rd_chk(codec_cfg_pkg::ADDR_CONF, 8'h0F);
        wr(codec_cfg_pkg::ADDR_RESET, 8'h80);
        check(8'(fr_n), 8'h01);
        rd_chk(codec_cfg_pkg::ADDR_PCM, 8'h40);
        rd_chk(codec_cfg_pkg::ADDR_CONF, 8'h00);
        wr(codec_cfg_pkg::ADDR_PCM, 8'h27);
        wr(codec_cfg_pkg::ADDR_LOOP, 8'h11);
        gci_mode_in <= 1'b1;
        repeat (20) @(posedge mclk_in);
        check({4'h0, msel}, 8'h02);
        dcl_on <= 1'b1;
        repeat (400) @(posedge mclk_in);
        check({gate, msel}, 8'hF1);
        check({2'b00, dbl, ofs, ah, dh}, 8'h00);
        dcl_half = 244;
        repeat (600) @(posedge mclk_in);
        check({4'h0, msel}, 8'h02);
        give_verdict();
    end
endmodule // codec_global_config_regs_tb
